//--- sim/hm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model
(
  input  wire logic       core_clk_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic            reg_from_smbus_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial
  begin
    reg_addr_o       = 8'h00;
    reg_wr_o         = 1'b0;
    reg_rd_o         = 1'b0;
    reg_from_smbus_o = 1'b1;
    reg_wdata_o      = 8'h00;
  end

  // one byte access; strobe held one cycle, data taken at next falling edge
  task automatic access(input  logic       is_wr,
                        input  logic [7:0] addr,
                        input  logic [7:0] data,
                        input  logic       smb,
                        output logic [7:0] q);
    @(negedge core_clk_i);
    reg_addr_o       = addr;
    reg_wdata_o      = data;
    reg_from_smbus_o = smb;
    reg_wr_o         = is_wr;
    reg_rd_o         = !is_wr;
    @(negedge core_clk_i);
    q        = reg_rdata_i;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    // released lines do not keep the last value
    reg_addr_o  = ~addr;
    reg_wdata_o = ~data;
  endtask : access
endmodule : smbus_host_model
`default_nettype wire

//--- sim/tb_health_monitor_start_and_status.sv
`timescale 1ns/1ps
`default_nettype none
module tb_health_monitor_start_and_status;
  import health_monitor_pkg::*;
  typedef logic [NUM_EVENT_CH-1:0][7:0] chan_t;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i    = 1'b0;
  logic [7:0]  addr, wdata, rdata, q;
  logic        wr, rd, smb;
  logic        init_done, pgood, svalid, s2_any;
  chan_t       smp, lo, hi;
  logic [2:0][7:0] ctrl, maxd, fans;
  logic        trip, mon_en, lock, clr, ro;
  logic [6:0]  st, last, v;
  int          err_total = 0;
  int          comparisons = 0;

  always #5 core_clk_i = ~core_clk_i;

  smbus_host_model smbus_host_model_inst (.core_clk_i(core_clk_i),
    .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_from_smbus_o(smb), .reg_wdata_o(wdata), .reg_rdata_i(rdata));

  health_monitor_start_and_status #(.NUM_FANS(3), .POWER_ON_WAIT_CYCLES(20))
  health_monitor_start_and_status_inst (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_from_smbus_i(smb), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .init_done_i(init_done), .main_power_good_i(pgood),
    .sample_valid_i(svalid), .sample_i(smp), .low_limit_i(lo),
    .high_limit_i(hi), .status2_any_i(s2_any), .fan_ctrl_duty_i(ctrl),
    .fan_max_duty_i(maxd), .fan_duty_output_o(fans),
    .thermal_trip_o(trip), .monitor_enable_o(mon_en),
    .config_lock_o(lock), .status_clear_o(clr), .smbus_read_only_o(ro));

  function automatic logic [6:0] expect_viol(input chan_t s, l, h);
    for (int c = 0; c < NUM_EVENT_CH; c++)
      if (c >= 4)
        expect_viol[c] = ($signed(s[c]) < $signed(l[c])) ||
                         ($signed(s[c]) > $signed(h[c]));
      else
        expect_viol[c] = (s[c] < l[c]) || (s[c] > h[c]);
  endfunction : expect_viol

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_reg(input logic [7:0] a, input logic s);
    smbus_host_model_inst.access(1'b0, a, 8'h00, s, q);
  endtask : rd_reg

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    smbus_host_model_inst.access(1'b1, a, d, 1'b0, q);
  endtask : wr_reg

  // one monitoring cycle, then let the status bit land
  task automatic send_sample();
    @(negedge core_clk_i);
    svalid = 1'b1;
    @(negedge core_clk_i);
    svalid = 1'b0;
    repeat (2) @(negedge core_clk_i);
  endtask : send_sample

  task automatic wrap_up();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  initial
  begin
    #100us;
    err_total++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(81));
    {init_done, pgood, svalid, s2_any} = 4'h0;
    smp  = {NUM_EVENT_CH{8'h6e}};
    lo   = {NUM_EVENT_CH{8'h20}};
    hi   = {NUM_EVENT_CH{8'h30}};
    ctrl = 24'($urandom) | 24'h010101;
    maxd = 24'($urandom) | 24'h808080;
    repeat (4) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    rd_reg(CFG_OFFSET, 1'b1);
    check(q, 8'h00);
    rd_reg(STATUS1_OFFSET, 1'b1);
    check(q, STATUS1_RESET);
    pgood = 1'b1;
    repeat (5) @(negedge core_clk_i);
    check(fans, 24'h0);
    repeat (30) @(negedge core_clk_i);
    check(fans, maxd);
    wr_reg(CFG_OFFSET, 8'h01);
    check(mon_en, 1'b0);
    wr_reg(CFG_OFFSET, 8'h00);
    @(negedge core_clk_i);
    init_done = 1'b1;
    @(negedge core_clk_i);
    init_done = 1'b0;
    rd_reg(CFG_OFFSET, 1'b1);
    check(q, 8'h04);
    send_sample();
    rd_reg(STATUS1_OFFSET, 1'b1);
    check(q, 8'h00);
    check(trip, 1'b0);
    check(mon_en, 1'b0);
    wr_reg(CFG_OFFSET, 8'he1);
    rd_reg(CFG_OFFSET, 1'b0);
    check(q, 8'he5);
    check({mon_en, clr}, 2'b10);
    @(negedge core_clk_i);
    check(fans, ctrl);
    st   = 7'h00;
    last = 7'h00;
    for (int i = 0; i < 40; i++)
    begin
      smp = chan_t'({$urandom, $urandom});
      lo  = chan_t'({$urandom, $urandom});
      hi  = chan_t'({$urandom, $urandom});
      if ($signed(smp[ZONE1_CH]) > $signed(TRIP_TEMP_C))
        smp[ZONE1_CH] = 8'h10;
      if (i == 0)
      begin
        lo = smp;
        hi = smp;
      end
      v = expect_viol(smp, lo, hi);
      st = st | v;
      last = v;
      send_sample();
      if (i % 3 == 1)
      begin
        rd_reg(STATUS1_OFFSET, 1'b0);
        check(q, 8'h00);
      end
      else
      begin
        rd_reg(STATUS1_OFFSET, 1'b1);
        check(q, {1'b0, st});
        st = last;
      end
    end
    s2_any = 1'b1;
    repeat (2) @(negedge core_clk_i);
    s2_any = 1'b0;
    rd_reg(STATUS1_OFFSET, 1'b1);
    check(q[7], 1'b1);
    rd_reg(STATUS1_OFFSET, 1'b1);
    check(q[7], 1'b1);
    rd_reg(STATUS2_OFFSET, 1'b1);
    rd_reg(STATUS1_OFFSET, 1'b1);
    check(q[7], 1'b1);
    rd_reg(STATUS1_OFFSET, 1'b1);
    check(q[7], 1'b0);
    wr_reg(CFG_OFFSET, 8'h03);
    wr_reg(CFG_OFFSET, 8'h00);
    rd_reg(CFG_OFFSET, 1'b1);
    check(q, 8'h06);
    check({lock, clr, mon_en}, 3'b110);
    rd_reg(STATUS1_OFFSET, 1'b1);
    check(q, 8'h00);
    check(fans, maxd);
    smp[ZONE1_CH] = 8'h6f;
    send_sample();
    check(trip, 1'b1);
    rst_n_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    check(fans, 24'h0);
    check({trip, lock, mon_en}, 3'b000);
    rd_reg(CFG_OFFSET, 1'b1);
    check(q, 8'h00);
    wr_reg(CFG_OFFSET, 8'h10);
    smbus_host_model_inst.access(1'b1, CFG_OFFSET, 8'h01, 1'b1, q);
    rd_reg(CFG_OFFSET, 1'b1);
    check({ro, q}, 9'h110);
    wrap_up();
  end
endmodule : tb_health_monitor_start_and_status
`default_nettype wire

//--- verilog/health_monitor_start_and_status.sv
// Summary of operation
// RULE_01: run-control clear disables limit-based monitoring and fan control.
// RULE_02: run-control clear clears all event status bits and holds them.
// RULE_03: unlocked registers writable while idle; effect only after start.
// RULE_04: run-control bit writable at all times, lock notwithstanding; SMBus writes are dropped here while SMBus access is read-only.
// RULE_05: run-control set enables monitoring and fan control.
// RULE_06: standby power-up reset forces run-control to zero.
// RULE_07: once ready, zone 1 above +110 C raises the thermal trip.
// RULE_08: after reset fan outputs stay at zero duty until wait or start; here override forces maximum duty even then.
// RULE_09: wait elapsed before start puts fans at their maximum duty.
// RULE_10: first status register readable only from SMBus, read-only there.
// RULE_11: bit 7 follows status two; clears after status two then one read.
// RULE_12: bits 6..4 flag zones 3..1 outside their temperature limits.
// RULE_13: bits 3..0 flag 5V, 3.3V, core, 2.5V outside their limits.
// RULE_14: set event bits hold until status one is read, then re-evaluated.
// RULE_15: event bit is one while a violation is latched; resets to zero.
// RULE_16: monitoring and fan control stay off while ready is zero.
// RULE_17: lock makes listed registers read-only; only reset clears it.
// RULE_18: each measurement is compared once per monitoring cycle.
`timescale 1ns/1ps
`default_nettype none
module health_monitor_start_and_status
  import health_monitor_pkg::*;
#(
  parameter int NUM_FANS             = 3,
  parameter int POWER_ON_WAIT_CYCLES = int'(POWER_WAIT_CYCLES)
)
(
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic [7:0]                   reg_addr_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  input  wire logic                         reg_from_smbus_i,
  input  wire logic [7:0]                   reg_wdata_i,
  output logic      [7:0]                   reg_rdata_o,
  input  wire logic                         init_done_i,
  input  wire logic                         main_power_good_i,
  input  wire logic                         sample_valid_i,
  input  wire logic [NUM_EVENT_CH-1:0][7:0] sample_i,
  input  wire logic [NUM_EVENT_CH-1:0][7:0] low_limit_i,
  input  wire logic [NUM_EVENT_CH-1:0][7:0] high_limit_i,
  input  wire logic                         status2_any_i,
  input  wire logic [NUM_FANS-1:0][7:0]     fan_ctrl_duty_i,
  input  wire logic [NUM_FANS-1:0][7:0]     fan_max_duty_i,
  output logic      [NUM_FANS-1:0][7:0]     fan_duty_output_o,
  output logic                              thermal_trip_o,
  output logic                              monitor_enable_o,
  output logic                              config_lock_o,
  output logic                              status_clear_o,
  output logic                              smbus_read_only_o
);

  localparam int WAIT_W = $clog2(POWER_ON_WAIT_CYCLES + 1);

  if (POWER_ON_WAIT_CYCLES < 1)
    $error("POWER_ON_WAIT_CYCLES must be at least one");
  if (NUM_FANS < 1 || NUM_FANS > 8)
    $error("NUM_FANS must lie in 1..8");

  logic                    cfg_start;
  logic                    cfg_lock;
  logic                    cfg_ready;
  logic                    cfg_override;
  logic                    cfg_smbus_ro;
  logic [CFG_RSVD_W-1:0]   cfg_rsvd;
  logic [7:0]              status1;
  logic [NUM_EVENT_CH-1:0] event_bits;
  logic                    summary_bit;
  logic [NUM_EVENT_CH-1:0] viol_now;
  logic [NUM_EVENT_CH-1:0] new_events;
  logic                    status2_read_seen;
  logic                    cfg_write;
  logic                    st1_read;
  logic                    st2_read;
  logic                    mon_run;
  logic                    pg_meta;
  logic                    pg_sync;
  logic [WAIT_W-1:0]       wait_count;
  logic                    wait_done;
  fan_mode_t               fan_mode;
  fan_mode_t               next_fan_mode;
  logic [7:0]              next_rdata;

  limit_check_if chk_bus ();

  limit_checker u_limit_checker
  (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .chk        (chk_bus.limit_side)
  );

  // smbus writes are dropped entirely while smbus access is read-only
  assign cfg_write = reg_wr_i && (reg_addr_i == CFG_OFFSET) &&
                     !(reg_from_smbus_i && cfg_smbus_ro);
  assign st1_read  = reg_rd_i && reg_from_smbus_i &&
                     (reg_addr_i == STATUS1_OFFSET); // RULE_10
  assign st2_read  = reg_rd_i && reg_from_smbus_i &&
                     (reg_addr_i == STATUS2_OFFSET);
  assign mon_run   = cfg_start && cfg_ready; // RULE_01 RULE_16

  assign monitor_enable_o  = mon_run; // RULE_03 RULE_05
  assign config_lock_o     = cfg_lock;
  assign status_clear_o    = !cfg_start; // RULE_02
  assign smbus_read_only_o = cfg_smbus_ro;

  // sample valid reaches the checker only while running; samples and limits always pass
  assign chk_bus.sample_valid = sample_valid_i && mon_run; // RULE_01
  assign chk_bus.sample       = sample_i;
  assign chk_bus.low_limit    = low_limit_i;
  assign chk_bus.high_limit   = high_limit_i;

  assign new_events = (chk_bus.violation_valid && mon_run) ?
                      chk_bus.violation : '0;
  assign status1    = {summary_bit, event_bits};

  // run control
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cfg_start <= CFG_RESET[CFG_START_BIT]; // RULE_06
    else if (cfg_write)
      cfg_start <= reg_wdata_i[CFG_START_BIT]; // RULE_04
  end

  // lock clears only on reset
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cfg_lock <= CFG_RESET[CFG_LOCK_BIT];
    else if (cfg_write && !cfg_lock)
      cfg_lock <= reg_wdata_i[CFG_LOCK_BIT]; // RULE_17
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cfg_ready <= CFG_RESET[CFG_READY_BIT];
    else if (init_done_i)
      cfg_ready <= 1'b1; // RULE_16
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_override <= CFG_RESET[CFG_OVERRIDE_BIT];
      cfg_rsvd     <= CFG_RESET[CFG_RSVD_LSB +: CFG_RSVD_W];
    end
    else if (cfg_write)
    begin
      cfg_override <= reg_wdata_i[CFG_OVERRIDE_BIT];
      cfg_rsvd     <= reg_wdata_i[CFG_RSVD_LSB +: CFG_RSVD_W];
    end
  end

  // smbus read-only bit is set from the lpc side only
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cfg_smbus_ro <= CFG_RESET[CFG_SMBUS_RO_BIT];
    else if (cfg_write && !reg_from_smbus_i)
      cfg_smbus_ro <= reg_wdata_i[CFG_SMBUS_RO_BIT];
  end

  // most recent comparison, used when a read re-arms the bits
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      viol_now <= '0;
    else if (!cfg_start)
      viol_now <= '0;
    else if (chk_bus.violation_valid && mon_run)
      viol_now <= chk_bus.violation;
  end

  // zone and supply events, new events win over a read
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      event_bits <= STATUS1_RESET[NUM_EVENT_CH-1:0]; // RULE_15
    else if (!cfg_start)
      event_bits <= '0; // RULE_02
    else if (st1_read)
      event_bits <= viol_now | new_events; // RULE_14
    else
      event_bits <= event_bits | new_events; // RULE_12 RULE_13
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      status2_read_seen <= 1'b0;
    else if (!cfg_start || st1_read)
      status2_read_seen <= 1'b0;
    else if (st2_read)
      status2_read_seen <= 1'b1;
  end

  // summary of the second status register
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      summary_bit <= STATUS1_RESET[ST1_SUMMARY_BIT];
    else if (!cfg_start)
      summary_bit <= 1'b0; // RULE_02
    else if (status2_any_i)
      summary_bit <= 1'b1; // RULE_11
    else if (st1_read && status2_read_seen)
      summary_bit <= 1'b0; // RULE_11
  end

  // thermal trip stays until standby reset
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      thermal_trip_o <= 1'b0;
    else if (cfg_ready && sample_valid_i &&
             $signed(sample_i[ZONE1_CH]) > TRIP_TEMP_C)
      thermal_trip_o <= 1'b1; // RULE_07
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pg_meta <= 1'b0;
      pg_sync <= 1'b0;
    end
    else
    begin
      pg_meta <= main_power_good_i;
      pg_sync <= pg_meta;
    end
  end

  // time since main power came on
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wait_count <= '0;
    else if (!pg_sync)
      wait_count <= '0;
    else if (!wait_done)
      wait_count <= wait_count + WAIT_W'(1);
  end

  assign wait_done = (wait_count == WAIT_W'(POWER_ON_WAIT_CYCLES));

  always_comb
  begin
    next_fan_mode = fan_mode;
    unique case (fan_mode)
      FAN_HOLD_ZERO:
        if (cfg_start)
          next_fan_mode = FAN_CONTROL;
        else if (wait_done)
          next_fan_mode = FAN_MAX; // RULE_09
      FAN_MAX:
        if (cfg_start)
          next_fan_mode = FAN_CONTROL;
      FAN_CONTROL:
        if (!cfg_start)
          next_fan_mode = FAN_MAX; // RULE_01
      default:
        next_fan_mode = FAN_HOLD_ZERO;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fan_mode <= FAN_HOLD_ZERO; // RULE_08
    else
      fan_mode <= next_fan_mode;
  end

  // override forces maximum duty in every mode
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fan_duty_output_o <= '0;
    else
      for (int f = 0; f < NUM_FANS; f++)
        if (cfg_override)
          fan_duty_output_o[f] <= fan_max_duty_i[f];
        else if (fan_mode == FAN_HOLD_ZERO)
          fan_duty_output_o[f] <= DUTY_ZERO; // RULE_08
        else if (fan_mode == FAN_CONTROL && cfg_ready)
          fan_duty_output_o[f] <= fan_ctrl_duty_i[f]; // RULE_05
        else
          fan_duty_output_o[f] <= fan_max_duty_i[f]; // RULE_09 RULE_16
  end

  always_comb
  begin
    next_rdata = READ_IDLE;
    if (reg_addr_i == CFG_OFFSET)
      next_rdata = {cfg_rsvd, cfg_smbus_ro, cfg_override, cfg_ready, cfg_lock,
                    cfg_start};
    else if (reg_addr_i == STATUS1_OFFSET && reg_from_smbus_i)
      next_rdata = status1; // RULE_10
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= READ_IDLE;
    else if (reg_rd_i)
      reg_rdata_o <= next_rdata;
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_idle_clears_status: // RULE_02
    assert property (!cfg_start |=> status1 == 8'h00)
    else $error("status not cleared while stopped");
  a_monitor_needs_start: // RULE_01
    assert property (!cfg_start |-> !monitor_enable_o &&
                     !chk_bus.sample_valid)
    else $error("monitoring active while stopped");
  a_monitor_needs_ready: // RULE_16
    assert property (!cfg_ready |-> !monitor_enable_o ##1 new_events == '0)
    else $error("monitoring active before ready");
  a_start_always_writable: // RULE_04
    assert property (cfg_write && cfg_lock |=>
                     cfg_start == $past(reg_wdata_i[CFG_START_BIT]))
    else $error("start write refused under lock");
  a_lock_sticky: // RULE_17
    assert property (cfg_lock |=> cfg_lock [*8])
    else $error("lock released without reset");
  a_fan_zero_hold: // RULE_08
    assert property (fan_mode == FAN_HOLD_ZERO && !cfg_override |=>
                     fan_duty_output_o == '0)
    else $error("fan duty nonzero before release");
  a_fan_max_after_wait: // RULE_09
    assert property (fan_mode == FAN_HOLD_ZERO && wait_done && !cfg_start
                     |=> fan_mode == FAN_MAX ##1
                     fan_duty_output_o == $past(fan_max_duty_i))
    else $error("fans not at maximum after wait");
  a_trip_on_hot: // RULE_07
    assert property (cfg_ready && sample_valid_i &&
                     $signed(sample_i[ZONE1_CH]) > TRIP_TEMP_C |=>
                     thermal_trip_o)
    else $error("thermal trip missed");
  a_events_latch: // RULE_12 RULE_13 RULE_18
    assert property (sample_valid_i && mon_run && cfg_start ##1 cfg_start
                     |=> (status1[6:0] & $past(chk_bus.violation)) ==
                     $past(chk_bus.violation))
    else $error("limit violation not latched");
  a_events_hold: // RULE_14
    assert property (cfg_start && !st1_read |=>
                     (status1[6:0] & $past(status1[6:0])) ==
                     $past(status1[6:0]))
    else $error("event bit dropped without read");
  a_summary_follows: // RULE_11
    assert property (cfg_start && status2_any_i |=> status1[ST1_SUMMARY_BIT])
    else $error("summary bit missed");
  a_lpc_status_hidden: // RULE_10
    assert property (reg_rd_i && !reg_from_smbus_i &&
                     reg_addr_i == STATUS1_OFFSET |=> reg_rdata_o == 8'h00)
    else $error("status one visible from lpc");

endmodule : health_monitor_start_and_status
`default_nettype wire

//--- verilog/hm_pkg.sv
`default_nettype none
package health_monitor_pkg;

  localparam logic [7:0] CFG_OFFSET     = 8'h40;
  localparam logic [7:0] STATUS1_OFFSET = 8'h41;
  localparam logic [7:0] STATUS2_OFFSET = 8'h42;

  localparam int CFG_START_BIT    = 0;
  localparam int CFG_LOCK_BIT     = 1;
  localparam int CFG_READY_BIT    = 2;
  localparam int CFG_OVERRIDE_BIT = 3;
  localparam int CFG_SMBUS_RO_BIT = 4;
  localparam int CFG_RSVD_LSB     = 5;
  localparam int CFG_RSVD_W       = 3;

  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] STATUS1_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE     = 8'h00;

  // event channel order equals status bit order 0..6
  localparam int NUM_EVENT_CH    = 7;
  localparam int ST1_SUMMARY_BIT = 7;
  localparam int ZONE1_CH        = 4;
  // temperature channels are two's complement
  localparam logic [6:0] SIGNED_CH = 7'h70;

  // +110 C trip point
  localparam logic signed [7:0] TRIP_TEMP_C = 8'sh6e;
  localparam logic [7:0]        DUTY_ZERO   = 8'h00;

  localparam longint CLK_PERIOD_NS     = 10;
  localparam longint POWER_WAIT_MS     = 2000;
  localparam longint POWER_WAIT_CYCLES =
    POWER_WAIT_MS * 64'd1000000 / CLK_PERIOD_NS;

  typedef enum logic [2:0]
  {
    FAN_HOLD_ZERO = 3'b001,
    FAN_MAX       = 3'b010,
    FAN_CONTROL   = 3'b100
  } fan_mode_t;

  function automatic logic out_of_range(input logic [7:0] value,
                                        input logic [7:0] low,
                                        input logic [7:0] high,
                                        input logic       is_signed);
    if (is_signed)
      out_of_range = ($signed(value) < $signed(low)) ||
                     ($signed(value) > $signed(high));
    else
      out_of_range = (value < low) || (value > high);
  endfunction : out_of_range

endpackage : health_monitor_pkg
`default_nettype wire

//--- verilog/limit_check_if.sv
`timescale 1ns/1ps
`default_nettype none
interface limit_check_if;
  import health_monitor_pkg::*;
  logic                              sample_valid;
  logic [NUM_EVENT_CH-1:0][7:0]      sample;
  logic [NUM_EVENT_CH-1:0][7:0]      low_limit;
  logic [NUM_EVENT_CH-1:0][7:0]      high_limit;
  logic [NUM_EVENT_CH-1:0]           violation;
  logic                              violation_valid;

  modport monitor_side (output sample_valid, sample, low_limit, high_limit,
                        input  violation, violation_valid);
  modport limit_side   (input  sample_valid, sample, low_limit, high_limit,
                        output violation, violation_valid);
endinterface : limit_check_if
`default_nettype wire

//--- verilog/limit_checker.sv
`timescale 1ns/1ps
`default_nettype none
module limit_checker
  import health_monitor_pkg::*;
(
  input  wire logic          core_clk_i,
  input  wire logic          rst_n_i,
  limit_check_if.limit_side  chk
);

  // one comparison per monitoring cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      chk.violation <= '0;
    else if (chk.sample_valid)
      for (int i = 0; i < NUM_EVENT_CH; i++)
        chk.violation[i] <= out_of_range(chk.sample[i], chk.low_limit[i],
                                         chk.high_limit[i],
                                         SIGNED_CH[i]); // RULE_18
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      chk.violation_valid <= 1'b0;
    else
      chk.violation_valid <= chk.sample_valid;
  end

endmodule : limit_checker
`default_nettype wire
